// *** design/rsw_pkg.sv ***
// package for the reset source and watchdog block
package rsw_pkg;
  // apb register byte offsets
  localparam logic [7:0] RSW_ADDR_WDOG = 8'h00; // watchdog_control_register
  localparam logic [7:0] RSW_ADDR_RSRC = 8'h04; // reset_source_register
  localparam logic [7:0] RSW_ADDR_CTRL = 8'h08; // oscillator_control_register / misc
  // watchdog command codes
  localparam logic [7:0] RSW_WD_KICK = 8'ha5;
  localparam logic [7:0] RSW_WD_DIS1 = 8'hde;
  localparam logic [7:0] RSW_WD_DIS2 = 8'had;
  localparam logic [7:0] RSW_WD_LOCK = 8'hff;
  localparam logic [2:0] RSW_WD_IVL_RST = 3'h7;
  localparam int RSW_WD_DIS_WIN = 4;
  localparam int RSW_WD_BITS = 21;
  localparam int RSW_WD_CMD_BIT = 7;
  localparam int RSW_WD_STAT_BIT = 4;
  // reset source register bit positions
  localparam int RSW_RS_PIN = 0;
  localparam int RSW_RS_POR = 1;
  localparam int RSW_RS_MCD = 2;
  localparam int RSW_RS_WDT = 3;
  localparam int RSW_RS_SW = 4;
  localparam int RSW_RS_CMP = 5;
  // control register bit positions
  localparam int RSW_CT_MCD_EN = 0;
  localparam int RSW_CT_SWRST = 1;
  // timing
  localparam int RSW_CLK_HZ = 50000000;
  localparam int RSW_POR_MS = 100;
  localparam int RSW_MCD_MS = 100;
  localparam int RSW_POR_CYC = RSW_CLK_HZ / 1000 * RSW_POR_MS;
  localparam int RSW_MCD_CYC = RSW_CLK_HZ / 1000 * RSW_MCD_MS;
  localparam int RSW_PIN_HOLD = 12;
  localparam logic [15:0] RSW_PC_RESET = 16'h0000;
  localparam logic [7:0] RSW_PORT_RESET = 8'hff;
  localparam logic [7:0] RSW_SP_RESET = 8'h07;
  // reset sequencer states
  typedef enum logic [1:0] {
    RSW_ST_RUN = 2'b00,
    RSW_ST_HOLD = 2'b01,
    RSW_ST_WAIT_CLK = 2'b10
  } rsw_state_t;
  // latched cause of the current reset
  typedef struct packed {
    logic cmp;
    logic sw;
    logic wdt;
    logic mcd;
    logic por;
    logic pin;
  } rsw_cause_t;
endpackage

// *** design/rsw_top.sv ***
// reset source merger, reset flags and watchdog with apb registers
//
// Overview of operation
// - in reset: cpu halted, ports known, registers defaulted, interrupts and timers off
// - on reset exit program counter goes to 0x0000
// - data memory untouched by reset; stack pointer restored
// - port latches load 0xff during and after reset
// - supply-monitor or software power-on reset drives reset pin low for 100 ms
// - clock defaults to internal 2 mhz oscillator; run only once stable
// - six reset sources: supply, pin, software, comparator, clock loss, watchdog
// - supply monitor active only while its enable pin is high
// - power-on reset sets power-on flag; other resets clear it
// - writing 1 to power-on flag forces full power-on reset
// - supply drop drives pin low, recovery exits like power-on
// - low reset pin resets; held twelve cycles after pin rises
// - pin reset sets the pin-reset flag on exit
// - enabled clock-loss detector resets after 100 ms stall; pin undriven
// - clock-loss flag set only after clock-loss reset
// - comparator reset enable makes low comparator result reset; pin undriven
// - comparator flag reads 1 only after comparator reset
// - watchdog overflow resets; pin undriven
// - watchdog runs at max interval after reset; disable or lock until reset
// - watchdog is a 21-bit counter on the system clock
// - writing 0xa5 enables and restarts watchdog
// - 0xde then 0xad within four clocks disables watchdog
// - writing 0xff locks out disable without restarting
// - bits 2..0 set timeout 4^(3+n) clocks; bit 7 low; resets to 111b
// - bit 4 reads watchdog active status
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module rsw_top
  import rsw_pkg::*;
#(
  parameter int POR_CYCLES = RSW_POR_CYC,
  parameter int MCD_CYCLES = RSW_MCD_CYC,
  parameter int PIN_HOLD = RSW_PIN_HOLD,
  parameter int OSC_STABLE = 16
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic rst_pin_n_i,
  output logic rst_pin_o,
  output logic rst_pin_oe_n_o,
  input wire logic supply_monitor_enable_pin_i,
  input wire logic supply_low_i,
  input wire logic comparator_out_i,
  input wire logic sysclk_alive_i,
  input wire logic osc_stable_i,
  output logic core_reset_o,
  output logic [15:0] program_counter_o,
  output logic [7:0] stack_pointer_o,
  output logic [7:0] port_latch_o,
  output logic irq_timer_enable_o,
  output logic [3:0] clock_select_o,
  output logic [1:0] state_o
);

  localparam int CW = 32;
  localparam logic [CW-1:0] ONE = 32'h00000001;
  localparam int SYNC_LAG = 2; // clocks the pin synchroniser lags the pin itself

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [1:0] pin_sync_reg;
  logic [1:0] sup_sync_reg;
  logic [1:0] cmp_sync_reg;
  logic [1:0] alive_sync_reg;
  logic [1:0] mon_sync_reg;
  logic [1:0] stab_sync_reg;

  // two flip-flops per outside input
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pin_sync_reg <= 2'h3;
      sup_sync_reg <= 2'h0;
      cmp_sync_reg <= 2'h3;
      alive_sync_reg <= 2'h0;
      mon_sync_reg <= 2'h0;
      stab_sync_reg <= 2'h0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], rst_pin_n_i};
      sup_sync_reg <= {sup_sync_reg[0], supply_low_i};
      cmp_sync_reg <= {cmp_sync_reg[0], comparator_out_i};
      alive_sync_reg <= {alive_sync_reg[0], sysclk_alive_i};
      mon_sync_reg <= {mon_sync_reg[0], supply_monitor_enable_pin_i};
      stab_sync_reg <= {stab_sync_reg[0], osc_stable_i};
    end
  end

  logic pin_n;
  logic sup_low;
  logic cmp_high;
  logic alive;
  logic mon_en;
  logic stable;
  assign pin_n = pin_sync_reg[1];
  assign sup_low = sup_sync_reg[1];
  assign cmp_high = cmp_sync_reg[1];
  assign alive = alive_sync_reg[1];
  assign mon_en = mon_sync_reg[1];
  assign stable = stab_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic wr_en;
  logic rd_en;
  assign wr_en = psel_i & penable_i & pwrite_i;
  assign rd_en = psel_i & ~penable_i & ~pwrite_i; // setup phase, so data stands at the access edge
  assign pready_o = 1'b1;

  rsw_state_t state_reg;
  logic in_reset;
  assign in_reset = (state_reg != RSW_ST_RUN);

  logic wd_write;
  logic rs_write;
  logic ct_write;
  logic [7:0] wbyte;
  assign wbyte = pwdata_i[7:0];
  assign wd_write = wr_en & ~in_reset & (paddr_i == RSW_ADDR_WDOG);
  assign rs_write = wr_en & ~in_reset & (paddr_i == RSW_ADDR_RSRC);
  assign ct_write = wr_en & ~in_reset & (paddr_i == RSW_ADDR_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // software controls
  logic cmp_rst_en_reg;
  logic mcd_en_reg;
  logic sw_por_req;
  logic sw_rst_req;

  // comparator enable and clock-loss enable clear on every reset
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || in_reset) begin
      cmp_rst_en_reg <= 1'b0;
      mcd_en_reg <= 1'b0;
    end else begin
      if (rs_write) begin
        cmp_rst_en_reg <= wbyte[RSW_RS_CMP];
      end
      if (ct_write) begin
        mcd_en_reg <= wbyte[RSW_CT_MCD_EN];
      end
    end
  end

  assign sw_por_req = rs_write & wbyte[RSW_RS_POR];
  assign sw_rst_req = (rs_write & wbyte[RSW_RS_SW]) | (ct_write & wbyte[RSW_CT_SWRST]);

  ////////////////////////////////////////////////////////////////////////////
  // clock-loss detector: counts cycles without an alive toggle
  logic alive_d_reg;
  logic [CW-1:0] mcd_cnt_reg;
  logic mcd_trip;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !mcd_en_reg) begin
      alive_d_reg <= 1'b0;
      mcd_cnt_reg <= '0;
    end else begin
      alive_d_reg <= alive;
      if (alive != alive_d_reg) begin
        mcd_cnt_reg <= '0;
      end else if (mcd_cnt_reg < CW'(MCD_CYCLES)) begin
        mcd_cnt_reg <= mcd_cnt_reg + ONE;
      end
    end
  end
  assign mcd_trip = mcd_en_reg & (mcd_cnt_reg >= CW'(MCD_CYCLES));

  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  logic wd_en_reg;
  logic wd_lock_reg;
  logic [2:0] wd_ivl_reg;
  logic [RSW_WD_BITS-1:0] wd_cnt_reg;
  logic de_pend_reg;
  logic [2:0] de_age_reg;
  logic wd_ovf;
  logic [RSW_WD_BITS:0] wd_limit;

  // timeout is 4^(3+n) = 2^(6+2n) clocks
  assign wd_limit = (RSW_WD_BITS + 1)'(1) << (6 + 2 * wd_ivl_reg);
  assign wd_ovf = wd_en_reg & ({1'b0, wd_cnt_reg} >= (wd_limit - 1'b1));

  // enable, lock and interval; reset leaves it running at max
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || in_reset) begin
      wd_en_reg <= 1'b1;
      wd_lock_reg <= 1'b0;
      wd_ivl_reg <= RSW_WD_IVL_RST;
    end else if (wd_write) begin
      if (wbyte == RSW_WD_KICK) begin
        wd_en_reg <= 1'b1;
      end else if (wbyte == RSW_WD_LOCK) begin
        wd_lock_reg <= 1'b1;
      end else if (wbyte == RSW_WD_DIS2 && de_pend_reg && !wd_lock_reg) begin
        wd_en_reg <= 1'b0;
      end else if (!wbyte[RSW_WD_CMD_BIT]) begin
        wd_ivl_reg <= wbyte[2:0];
      end
    end
  end

  // first half of the disable pair stays armed for four clocks
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || in_reset) begin
      de_pend_reg <= 1'b0;
      de_age_reg <= 3'h0;
    end else if (wd_write) begin
      de_pend_reg <= (wbyte == RSW_WD_DIS1);
      de_age_reg <= 3'h0;
    end else if (de_pend_reg) begin
      if (32'(de_age_reg) >= RSW_WD_DIS_WIN - 1) begin
        de_pend_reg <= 1'b0;
      end
      de_age_reg <= de_age_reg + 3'h1;
    end
  end

  // 21-bit counter, restarted by the kick code
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || in_reset || !wd_en_reg) begin
      wd_cnt_reg <= '0;
    end else if (wd_write && wbyte == RSW_WD_KICK) begin
      wd_cnt_reg <= '0;
    end else begin
      wd_cnt_reg <= wd_cnt_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset sequencer
  rsw_cause_t cause_reg;
  rsw_cause_t cause_now;
  rsw_cause_t flags_reg;
  logic [CW-1:0] hold_cnt_reg;
  logic por_src;
  logic any_src;
  logic pin_drive;
  logic pin_own;

  // merge of the six sources
  always_comb begin
    cause_now.por = (mon_en & sup_low) | sw_por_req;
    cause_now.pin = ~pin_n & ~pin_own;
    cause_now.sw = sw_rst_req;
    cause_now.cmp = cmp_rst_en_reg & ~cmp_high;
    cause_now.mcd = mcd_trip;
    cause_now.wdt = wd_ovf;
  end
  assign any_src = |cause_now;
  assign por_src = cause_now.por;

  // hold count: 100 ms for power-on, twelve cycles after pin release
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_reg <= RSW_ST_HOLD;
      cause_reg <= '0;
      cause_reg.por <= 1'b1; // system reset leaves like a power-on
      hold_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        RSW_ST_RUN: begin
          if (any_src) begin
            state_reg <= RSW_ST_HOLD;
            cause_reg <= cause_now;
            hold_cnt_reg <= '0;
          end
        end
        RSW_ST_HOLD: begin
          cause_reg <= cause_reg | cause_now;
          if (por_src || (cause_reg.pin && !pin_n && !pin_own)) begin
            hold_cnt_reg <= '0;
          end else if (cause_reg.por && hold_cnt_reg < CW'(POR_CYCLES + PIN_HOLD)) begin
            hold_cnt_reg <= hold_cnt_reg + ONE; // drive, then twelve quiet clocks
          end else if (hold_cnt_reg < CW'(PIN_HOLD)) begin
            hold_cnt_reg <= hold_cnt_reg + ONE;
          end else begin
            state_reg <= RSW_ST_WAIT_CLK;
          end
        end
        RSW_ST_WAIT_CLK: begin
          if (any_src) begin
            state_reg <= RSW_ST_HOLD;
            cause_reg <= cause_reg | cause_now;
            hold_cnt_reg <= '0;
          end else if (stable) begin
            state_reg <= RSW_ST_RUN;
          end
        end
        default: begin
          state_reg <= RSW_ST_HOLD;
        end
      endcase
    end
  end

  // reset pin driven low only for power-on class resets
  assign pin_drive = (state_reg == RSW_ST_HOLD) & cause_reg.por
    & (hold_cnt_reg < CW'(POR_CYCLES));
  // our own drive echoes through the pin synchroniser; that echo is no pin reset
  assign pin_own = cause_reg.por & (hold_cnt_reg < CW'(POR_CYCLES + SYNC_LAG));

  // flags captured at release, one source reported
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      flags_reg <= '0;
      flags_reg.por <= 1'b1;
    end else if (state_reg == RSW_ST_WAIT_CLK && stable && !any_src) begin
      flags_reg <= '0;
      if (cause_reg.por) begin
        flags_reg.por <= 1'b1;
      end else if (cause_reg.pin) begin
        flags_reg.pin <= 1'b1;
      end else if (cause_reg.mcd) begin
        flags_reg.mcd <= 1'b1;
      end else if (cause_reg.cmp) begin
        flags_reg.cmp <= 1'b1;
      end else if (cause_reg.wdt) begin
        flags_reg.wdt <= 1'b1;
      end else begin
        flags_reg.sw <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core-facing outputs; data memory has no reset path at all
  logic [15:0] pc_reg;
  logic [7:0] sp_reg;
  logic [7:0] port_reg;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || in_reset) begin
      pc_reg <= RSW_PC_RESET;
      sp_reg <= RSW_SP_RESET;
      port_reg <= RSW_PORT_RESET;
    end
  end

  assign core_reset_o = rst_i | in_reset;
  assign irq_timer_enable_o = ~(rst_i | in_reset);
  assign program_counter_o = pc_reg;
  assign stack_pointer_o = sp_reg;
  assign port_latch_o = port_reg;
  assign clock_select_o = 4'h0; // internal 2 mhz oscillator
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe_n_o = ~pin_drive;
  assign state_o = state_reg;

  ////////////////////////////////////////////////////////////////////////////
  // apb read data
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (paddr_i == RSW_ADDR_WDOG) begin
      rd_byte[2:0] = wd_ivl_reg;
      rd_byte[RSW_WD_STAT_BIT] = wd_en_reg;
    end else if (paddr_i == RSW_ADDR_RSRC) begin
      rd_byte[RSW_RS_PIN] = flags_reg.pin;
      rd_byte[RSW_RS_POR] = flags_reg.por;
      rd_byte[RSW_RS_MCD] = flags_reg.mcd;
      rd_byte[RSW_RS_WDT] = flags_reg.wdt;
      rd_byte[RSW_RS_SW] = flags_reg.sw;
      rd_byte[RSW_RS_CMP] = flags_reg.cmp;
    end else if (paddr_i == RSW_ADDR_CTRL) begin
      rd_byte[RSW_CT_MCD_EN] = mcd_en_reg;
    end
  end

  logic unmapped;
  assign unmapped = (paddr_i != RSW_ADDR_WDOG) && (paddr_i != RSW_ADDR_RSRC)
    && (paddr_i != RSW_ADDR_CTRL);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h00000000;
    end else if (rd_en) begin
      prdata_o <= {24'h000000, rd_byte};
    end
  end
  assign pslverr_o = psel_i & penable_i & unmapped;

endmodule
`default_nettype wire

// *** sim/rsw_checker.sv ***
// assertion checker for the reset source and watchdog block
`timescale 1ns/1ps
`default_nettype none
module rsw_checker
  import rsw_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic pslverr_o,
  input wire logic rst_pin_n_i,
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe_n_o,
  input wire logic osc_stable_i,
  input wire logic core_reset_o,
  input wire logic [15:0] program_counter_o,
  input wire logic [7:0] stack_pointer_o,
  input wire logic [7:0] port_latch_o,
  input wire logic irq_timer_enable_o,
  input wire logic [3:0] clock_select_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic [3:0] hi_cnt;
  // cycles the reset pin has stayed high, saturating
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !rst_pin_n_i) begin
      hi_cnt <= 4'h0;
    end else if (hi_cnt != 4'hf) begin
      hi_cnt <= hi_cnt + 4'h1;
    end
  end
  ////////////////////////////////////////
  a_pc_exit_zero: assert property (core_reset_o |=> program_counter_o == 16'h0000)
    else $error("program counter not cleared by reset");
  a_sp_restored: assert property (core_reset_o |=> stack_pointer_o == RSW_SP_RESET)
    else $error("stack pointer not restored by reset");
  a_port_high: assert property (core_reset_o |=> port_latch_o == 8'hff)
    else $error("port latches not high in reset");
  a_irq_off: assert property (core_reset_o |-> !irq_timer_enable_o)
    else $error("interrupts enabled in reset");
  a_pin_release: assert property ($fell(core_reset_o) |-> hi_cnt >= 4'hc)
    else $error("reset left too soon after pin release");
  a_pin_drive_low: assert property (!rst_pin_oe_n_o |-> !rst_pin_o && core_reset_o)
    else $error("reset pin driven wrongly");
  a_clk_default: assert property ($fell(core_reset_o) |-> clock_select_o == 4'h0)
    else $error("clock source not internal at exit");
  a_run_osc: assert property ($fell(core_reset_o) |-> $past(osc_stable_i, 2))
    else $error("run started before oscillator stable");
  a_unmapped_err: assert property (psel_i && penable_i && paddr_i == 8'h0c |-> pslverr_o)
    else $error("unmapped access not flagged");
endmodule
bind rsw_top rsw_checker i_chk (
  .ref_clk_i(ref_clk_i),
  .rst_i(rst_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .paddr_i(paddr_i),
  .pslverr_o(pslverr_o),
  .rst_pin_n_i(rst_pin_n_i),
  .rst_pin_o(rst_pin_o),
  .rst_pin_oe_n_o(rst_pin_oe_n_o),
  .osc_stable_i(osc_stable_i),
  .core_reset_o(core_reset_o),
  .program_counter_o(program_counter_o),
  .stack_pointer_o(stack_pointer_o),
  .port_latch_o(port_latch_o),
  .irq_timer_enable_o(irq_timer_enable_o),
  .clock_select_o(clock_select_o)
);
`default_nettype wire

// *** sim/rsw_far_side.sv ***
// far-side model: reset pin, supply, comparator and clock sources
`timescale 1ns/1ps
`default_nettype none
module rsw_far_side (
  input wire logic ref_clk_i,
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe_n_o,
  input wire logic ext_low_i,
  input wire logic sup_low_i,
  input wire logic cmp_low_i,
  input wire logic clk_stop_i,
  output logic rst_pin_n_o,
  output logic supply_low_o,
  output logic comparator_out_o,
  output var logic sysclk_alive_o,
  output logic osc_stable_o
);
  // pulled-up pin, low when either party pulls it
  assign rst_pin_n_o = !(ext_low_i || (!rst_pin_oe_n_o && !rst_pin_o));
  assign supply_low_o = sup_low_i;
  assign comparator_out_o = !cmp_low_i;
  assign osc_stable_o = 1'b1;
  // activity line toggles every cycle unless the clock is stopped
  initial sysclk_alive_o = 1'b0;
  always @(posedge ref_clk_i) begin
    if (!clk_stop_i) begin
      sysclk_alive_o <= !sysclk_alive_o;
    end
  end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking testbench for the reset source and watchdog block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rsw_pkg::*;
  localparam int POR_N = 50;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, q_v;
  logic pready, pslverr, e_v, pin_n, pin_o, pin_oe_n;
  logic mon_en = 1'b1, ext_low = 1'b0, sup_low = 1'b0;
  logic cmp_low = 1'b0, clk_stop = 1'b0;
  logic sup, cmp, alive, osc, core_rst, irq_en;
  logic [15:0] pc;
  logic [7:0] sp, port;
  logic [3:0] clk_sel;
  logic [1:0] st;
  int fails = 0, comparisons = 0, drv_n = 0, n;
  always #10 ref_clk_i = !ref_clk_i;
  // cycles the device pulls its reset pin low
  always @(posedge ref_clk_i) begin
    if (!pin_oe_n) begin
      drv_n <= drv_n + 1;
    end
  end
  rsw_top #(.POR_CYCLES(POR_N), .MCD_CYCLES(40), .PIN_HOLD(12), .OSC_STABLE(16)) i_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .rst_pin_n_i(pin_n), .rst_pin_o(pin_o),
    .rst_pin_oe_n_o(pin_oe_n), .supply_monitor_enable_pin_i(mon_en),
    .supply_low_i(sup), .comparator_out_i(cmp), .sysclk_alive_i(alive),
    .osc_stable_i(osc), .core_reset_o(core_rst), .program_counter_o(pc),
    .stack_pointer_o(sp), .port_latch_o(port), .irq_timer_enable_o(irq_en),
    .clock_select_o(clk_sel), .state_o(st)
  );
  rsw_far_side i_far (
    .ref_clk_i(ref_clk_i), .rst_pin_o(pin_o), .rst_pin_oe_n_o(pin_oe_n),
    .ext_low_i(ext_low), .sup_low_i(sup_low), .cmp_low_i(cmp_low),
    .clk_stop_i(clk_stop), .rst_pin_n_o(pin_n), .supply_low_o(sup),
    .comparator_out_o(cmp), .sysclk_alive_o(alive), .osc_stable_o(osc)
  );
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (x !== g) begin
      fails++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask
  // one apb transfer: setup, then access held until pready; data taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk_i);
    pen <= 1'b1;
    do begin
      @(posedge ref_clk_i);
    end while (pready !== 1'b1);
    e_v = pslverr;
    q_v = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 8'h0);
    chk(x, q_v);
  endtask
  // wait for core reset to reach level v, bounded
  task automatic till(input logic v);
    n = 0;
    while (core_rst !== v && n < 3000) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk({31'h0, v}, {31'h0, core_rst});
  endtask
  task automatic t_boot();
    chk(32'hff, {24'h0, port});
    chk(32'h0, {28'h0, clk_sel});
    chk({30'h0, RSW_ST_RUN}, {30'h0, st});
    rd(RSW_ADDR_WDOG, 32'h17);
    rd(RSW_ADDR_RSRC, 32'h02);
    rd(8'h0c, 32'h0);
    chk(32'h1, {31'h0, e_v});
  endtask
  task automatic t_lock();
    apb(1'b1, RSW_ADDR_WDOG, RSW_WD_LOCK);
    apb(1'b1, RSW_ADDR_WDOG, RSW_WD_DIS1);
    apb(1'b1, RSW_ADDR_WDOG, RSW_WD_DIS2);
    rd(RSW_ADDR_WDOG, 32'h17);
  endtask
  task automatic t_pin();
    ext_low <= 1'b1;
    till(1'b1);
    chk({30'h0, RSW_ST_HOLD}, {30'h0, st});
    repeat (3) @(posedge ref_clk_i);
    ext_low <= 1'b0;
    till(1'b0);
    chk(32'h1, {31'h0, n >= 12});
    rd(RSW_ADDR_RSRC, 32'h01);
  endtask
  task automatic t_dis();
    apb(1'b1, RSW_ADDR_WDOG, RSW_WD_DIS1);
    apb(1'b1, RSW_ADDR_WDOG, RSW_WD_DIS2);
    rd(RSW_ADDR_WDOG, 32'h07);
    apb(1'b1, RSW_ADDR_WDOG, RSW_WD_KICK);
    rd(RSW_ADDR_WDOG, 32'h17);
    apb(1'b1, RSW_ADDR_WDOG, RSW_WD_DIS1);
    repeat (6) @(posedge ref_clk_i);
    apb(1'b1, RSW_ADDR_WDOG, RSW_WD_DIS2);
    rd(RSW_ADDR_WDOG, 32'h17);
  endtask
  task automatic t_por();
    drv_n = 0;
    apb(1'b1, RSW_ADDR_RSRC, 8'h02);
    till(1'b1);
    till(1'b0);
    chk(32'h1, {31'h0, drv_n >= POR_N});
    rd(RSW_ADDR_RSRC, 32'h02);
  endtask
  task automatic t_sup();
    mon_en <= 1'b0;
    sup_low <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    chk(32'h0, {31'h0, core_rst});
    mon_en <= 1'b1;
    drv_n = 0;
    till(1'b1);
    sup_low <= 1'b0;
    till(1'b0);
    chk(32'h1, {31'h0, drv_n >= POR_N});
    rd(RSW_ADDR_RSRC, 32'h02);
  endtask
  task automatic t_wdog();
    apb(1'b1, RSW_ADDR_WDOG, 8'h00);
    apb(1'b1, RSW_ADDR_WDOG, RSW_WD_KICK);
    drv_n = 0;
    till(1'b1);
    chk(32'h1, {31'h0, n >= 58 && n <= 68});
    till(1'b0);
    chk(32'h0, drv_n);
    rd(RSW_ADDR_RSRC, 32'h08);
  endtask
  task automatic t_mcd();
    apb(1'b1, RSW_ADDR_CTRL, 8'h01);
    clk_stop <= 1'b1;
    drv_n = 0;
    till(1'b1);
    chk(32'h1, {31'h0, n >= 30 && n <= 60});
    clk_stop <= 1'b0;
    till(1'b0);
    chk(32'h0, drv_n);
    rd(RSW_ADDR_RSRC, 32'h04);
  endtask
  task automatic t_cmp();
    apb(1'b1, RSW_ADDR_RSRC, 8'h20);
    cmp_low <= 1'b1;
    drv_n = 0;
    till(1'b1);
    cmp_low <= 1'b0;
    till(1'b0);
    chk(32'h0, drv_n);
    rd(RSW_ADDR_RSRC, 32'h20);
  endtask
  task automatic wrap_up();
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    till(1'b0);
    t_boot();
    t_lock();
    t_pin();
    t_dis();
    t_por();
    t_sup();
    t_wdog();
    t_mcd();
    t_cmp();
    wrap_up();
  end
  // cut a hang short
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fails++;
    wrap_up();
  end
endmodule
`default_nettype wire
